// ### inc/psri_pkg.sv
// Purpose: constants and types for the pseudo-static ram host controller
// Assumes: 40 MHz core clock, slowest speed grade timing by default
// Notes: times are kept in ns; cycle counts derive from them
package psri_pkg;
   localparam int unsigned PSRI_CLK_MHZ = 40;
   localparam int unsigned PSRI_ADDR_W = 19;
   localparam int unsigned PSRI_DATA_W = 8;
   localparam int unsigned PSRI_ROW_W = 11;
   localparam int unsigned PSRI_ROWS = 2048;
   // slowest grade figures, so any grade of part is served
   localparam int unsigned PSRI_T_CE_MIN_NS = 100;
   localparam int unsigned PSRI_T_CE_MAX_NS = 10000;
   localparam int unsigned PSRI_T_P_NS = 50;
   localparam int unsigned PSRI_T_RC_NS = 160;
   localparam int unsigned PSRI_T_RMW_NS = 220;
   localparam int unsigned PSRI_T_WP_NS = 30;
   localparam int unsigned PSRI_T_FC_NS = 160;
   localparam int unsigned PSRI_T_RFD_NS = 50;
   localparam int unsigned PSRI_T_FAP_MIN_NS = 30;
   localparam int unsigned PSRI_T_FAP_MAX_NS = 8000;
   localparam int unsigned PSRI_T_FP_NS = 30;
   localparam int unsigned PSRI_T_FRS_NS = 190;
   localparam int unsigned PSRI_T_PAUSE_NS = 100000;
   localparam int unsigned PSRI_T_REF_NS = 32000000;

   function automatic int unsigned psri_cyc_min(input int unsigned ns);
      int unsigned c;
      c = (ns * PSRI_CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction : psri_cyc_min

   function automatic int unsigned psri_cyc_max(input int unsigned ns);
      int unsigned c;
      c = (ns * PSRI_CLK_MHZ) / 1000;
      return (c < 1) ? 1 : c;
   endfunction : psri_cyc_max

   localparam int unsigned PSRI_CE_LOW_CYC = psri_cyc_min(PSRI_T_CE_MIN_NS);
   localparam int unsigned PSRI_CE_HIGH_CYC = psri_cyc_min(PSRI_T_P_NS);
   localparam int unsigned PSRI_RC_CYC = psri_cyc_min(PSRI_T_RC_NS);
   localparam int unsigned PSRI_RMW_CYC = psri_cyc_min(PSRI_T_RMW_NS);
   localparam int unsigned PSRI_WP_CYC = psri_cyc_min(PSRI_T_WP_NS);
   localparam int unsigned PSRI_FC_CYC = psri_cyc_min(PSRI_T_FC_NS);
   localparam int unsigned PSRI_RFD_CYC = psri_cyc_min(PSRI_T_RFD_NS);
   localparam int unsigned PSRI_FAP_CYC = psri_cyc_min(PSRI_T_FAP_MIN_NS);
   localparam int unsigned PSRI_FP_CYC = psri_cyc_min(PSRI_T_FP_NS);
   localparam int unsigned PSRI_FRS_CYC = psri_cyc_min(PSRI_T_FRS_NS);
   localparam int unsigned PSRI_SELF_CYC = psri_cyc_min(PSRI_T_FAP_MAX_NS);
   localparam int unsigned PSRI_PAUSE_CYC = psri_cyc_min(PSRI_T_PAUSE_NS);
   // refresh interval: 2048 refreshes per period, rounded down
   localparam int unsigned PSRI_REF_INT_CYC =
      psri_cyc_max(PSRI_T_REF_NS / PSRI_ROWS);

   typedef enum logic [1:0] {
      PSRI_OP_READ,
      PSRI_OP_WRITE,
      PSRI_OP_RMW
   } psri_op_type;

   typedef struct packed {
      psri_op_type op;
      logic [PSRI_ADDR_W-1:0] addr;
      logic [PSRI_DATA_W-1:0] wdata;
   } psri_req_type;

   typedef struct packed {
      logic ce_n;
      logic output_enable_or_refresh_n;
      logic rw_n;
      logic [PSRI_ADDR_W-1:0] addr_bus;
      logic [PSRI_DATA_W-1:0] data_out;
      logic data_oe_n;
   } psri_pins_type;
endpackage : psri_pkg

// ### rtl/psri_ctrl.sv
// Purpose: host-side controller driving a 512k x 8 pseudo-static ram
// Assumes: pins and user inputs synchronous to core_clk_i
// Notes: auto refresh keeps the part alive; sleep_i enters self refresh
`timescale 1ns/10ps
// Function
// R1: memory holds 524288 bytes, 19-bit address
// R2: address captured at chip enable fall
// R3: write data latched at first rising edge
// R4: chip enable and output enable low reads
// R5: outputs float unless reading
// R6: chip-enable-only refresh uses latched row
// R7: refresh pin low alone refreshes internally
// R8: both high means standby
// R9: device counter and timer serve refresh
// R10: short refresh pulse gives one auto refresh
// R11: refresh pulse past 8000 ns self refreshes
// R12: refresh pin high 30 ns between pulses
// R13: auto refreshes at least t_fc apart
// R14: wait after chip enable rise before refresh
// R15: chip enable high after self refresh
// R16: 2048 refreshes every 32 ms
// R17: chip-enable-only refresh steps eleven row bits
// R18: chip enable low pulse width bounds
// R19: chip enable precharge between accesses
// R20: access cycles at least t_rc apart
// R21: read-modify-write cycle at least t_rmw
// R22: write pulse width and lead to rise
// R23: 100 us pause after power-up
// R24: device row counter advances per auto refresh
module psri_ctrl
   import psri_pkg::*;
#(
   parameter int unsigned PAUSE_CYC = PSRI_PAUSE_CYC,
   parameter int unsigned SELF_CYC = PSRI_SELF_CYC,
   parameter int unsigned REF_INT_CYC = PSRI_REF_INT_CYC
) (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic clk_en_i,
   input wire psri_req_type req_i,
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire logic sleep_i,
   output logic rdata_valid_o,
   output logic [PSRI_DATA_W-1:0] rdata_o,
   output logic in_self_refresh_o,
   output logic ce_n_o,
   output logic output_enable_or_refresh_n_o,
   output logic rw_n_o,
   output logic [PSRI_ADDR_W-1:0] addr_bus_o,
   output logic [PSRI_DATA_W-1:0] data_pins_o,
   output logic data_pins_oe_n_o,
   input wire logic [PSRI_DATA_W-1:0] data_pins_i
);
   typedef enum logic [3:0] {
      PSRI_S_PAUSE, PSRI_S_IDLE, PSRI_S_ACC, PSRI_S_PRE, PSRI_S_RFD,
      PSRI_S_REFRESH_REQUEST_N, PSRI_S_FP, PSRI_S_SELF, PSRI_S_FRS
   } psri_state_type;

   localparam int CW = 18;
   psri_state_type state_r;
   logic [CW-1:0] tmr_r;
   logic [CW-1:0] cyc_r;
   logic [CW-1:0] ref_r;
   logic [4:0] owed_r;
   psri_req_type cur_r;
   logic wr_phase_r;

   function automatic logic [CW-1:0] c(input int unsigned v);
      return v[CW-1:0];
   endfunction : c

   wire logic ref_due = (owed_r != 5'h00);
   wire logic ref_tick = (ref_r >= c(REF_INT_CYC - 1));
   wire logic ref_paid = (state_r == PSRI_S_REFRESH_REQUEST_N) && (tmr_r == c(1));
   // an access may start only from idle, with no refresh owed and no sleep request
   wire logic acc_ok = (state_r == PSRI_S_IDLE) && !ref_due && !sleep_i;
   assign req_ready_o = acc_ok;
   assign in_self_refresh_o = (state_r == PSRI_S_SELF);

   // refresh interval counter, free running outside reset while clk_en_i is high
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ref_r <= '0;
      end else if (clk_en_i) begin
         ref_r <= ref_tick ? '0 : ref_r + c(1);
      end
   end

   // refresh debt: one owed per interval, paid by each auto refresh
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         owed_r <= 5'h00;
      end else if (clk_en_i) begin
         // self refresh keeps data on its own, so debt is dropped
         if (state_r == PSRI_S_SELF)
            owed_r <= 5'h00;
         else if (ref_tick && !ref_paid && owed_r != 5'h1f) // see R16
            owed_r <= owed_r + 5'h01;
         else if (!ref_tick && ref_paid)
            owed_r <= owed_r - 5'h01;
      end
   end

   // cycle-start spacing counter for t_rc / t_rmw / t_fc
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cyc_r <= '0;
      end else if (clk_en_i) begin
         if (state_r == PSRI_S_IDLE && req_valid_i && acc_ok) begin
            // see R20 R21
            cyc_r <= (req_i.op == PSRI_OP_RMW) ? c(PSRI_RMW_CYC)
                                               : c(PSRI_RC_CYC);
         end else if (state_r == PSRI_S_RFD && tmr_r == c(1)) begin
            cyc_r <= c(PSRI_FC_CYC); // see R13
         end else if (cyc_r != '0) begin
            cyc_r <= cyc_r - c(1);
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r <= PSRI_S_PAUSE;
         tmr_r <= '0;
         cur_r <= '0;
         wr_phase_r <= 1'b0;
      end else if (clk_en_i) begin
         if (tmr_r != '0)
            tmr_r <= tmr_r - c(1);
         case (state_r)
            PSRI_S_PAUSE: begin
               // chip enable held high through the power-up pause
               if (tmr_r == '0 && wr_phase_r) begin // see R23
                  state_r <= PSRI_S_IDLE;
                  wr_phase_r <= 1'b0;
               end else if (!wr_phase_r) begin
                  tmr_r <= c(PAUSE_CYC);
                  wr_phase_r <= 1'b1;
               end
            end
            PSRI_S_IDLE: begin
               if (ref_due && cyc_r == '0) begin
                  state_r <= PSRI_S_REFRESH_REQUEST_N; // see R14
                  tmr_r <= c(PSRI_FAP_CYC); // see R10
               end else if (sleep_i && !ref_due && cyc_r == '0) begin
                  state_r <= PSRI_S_SELF; // see R11
                  tmr_r <= c(SELF_CYC);
               end else if (req_valid_i && acc_ok) begin
                  state_r <= PSRI_S_ACC; // see R2
                  cur_r <= req_i;
                  wr_phase_r <= 1'b0;
                  tmr_r <= c(PSRI_CE_LOW_CYC); // see R18
               end
            end
            PSRI_S_ACC: begin
               // rmw: read for t_ce, then a t_wp strobe before ce rises
               if (tmr_r == c(1)) begin
                  if (cur_r.op == PSRI_OP_RMW && !wr_phase_r) begin
                     wr_phase_r <= 1'b1;
                     tmr_r <= c(PSRI_WP_CYC); // see R22
                  end else begin
                     state_r <= PSRI_S_PRE;
                     tmr_r <= c(PSRI_RFD_CYC); // see R19 R14
                  end
               end
            end
            PSRI_S_PRE: begin
               if (tmr_r <= c(1))
                  state_r <= PSRI_S_IDLE;
            end
            PSRI_S_REFRESH_REQUEST_N: begin
               if (tmr_r == c(1)) begin
                  state_r <= PSRI_S_FP;
                  tmr_r <= c(PSRI_FP_CYC); // see R12
               end
            end
            PSRI_S_FP: begin
               if (tmr_r <= c(1)) begin
                  state_r <= PSRI_S_RFD;
                  tmr_r <= c(1);
               end
            end
            PSRI_S_RFD: begin
               // one-cycle hop that restarts t_fc spacing
               state_r <= PSRI_S_IDLE;
            end
            PSRI_S_SELF: begin
               // pulse must outlast 8000 ns even if sleep drops early
               if (!sleep_i && tmr_r == '0) begin
                  state_r <= PSRI_S_FRS;
                  tmr_r <= c(PSRI_FRS_CYC); // see R15
               end
            end
            PSRI_S_FRS: begin
               if (tmr_r <= c(1))
                  state_r <= PSRI_S_IDLE;
            end
            default: state_r <= PSRI_S_IDLE;
         endcase
      end
   end

   // next pin levels; each pin flop below takes its own share
   logic acc_nxt;
   logic wr_nxt;
   logic rf_nxt;
   logic start_refresh_request_n;
   logic start_self;

   // refresh starts wait out the spacing left by the last cycle
   assign start_refresh_request_n = (state_r == PSRI_S_IDLE) && ref_due && (cyc_r == '0);
   assign start_self = (state_r == PSRI_S_IDLE) && sleep_i && !ref_due &&
                       (cyc_r == '0);

   always_comb begin
      acc_nxt = 1'b0;
      wr_nxt = 1'b0;
      rf_nxt = 1'b0;
      case (state_r)
         PSRI_S_IDLE: begin
            acc_nxt = !ref_due && !sleep_i && req_valid_i;
            wr_nxt = (req_i.op == PSRI_OP_WRITE);
            // auto and self refresh only, rows come from the ram's counter; see R17
            rf_nxt = start_refresh_request_n || start_self;
         end
         PSRI_S_ACC: begin
            acc_nxt = !(tmr_r == c(1) &&
                        !(cur_r.op == PSRI_OP_RMW && !wr_phase_r));
            // write strobe low the whole pulse, or the rmw tail only
            wr_nxt = (cur_r.op == PSRI_OP_WRITE) ||
                     (cur_r.op == PSRI_OP_RMW &&
                      (wr_phase_r || tmr_r == c(1)));
         end
         PSRI_S_REFRESH_REQUEST_N: rf_nxt = (tmr_r != c(1));
         PSRI_S_SELF: rf_nxt = !(!sleep_i && tmr_r == '0);
         default: rf_nxt = 1'b0;
      endcase
   end

   // pins come from flops so the ram never sees a glitch
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ce_n_o <= 1'b1;
         rw_n_o <= 1'b1;
      end else if (clk_en_i) begin
         // strobe and enable rise on one edge; data latches there
         ce_n_o <= !acc_nxt; // see R18 R19
         rw_n_o <= !(acc_nxt && wr_nxt); // see R3 R22
      end
   end

   // read enable and refresh share one pin; writes leave it high
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         output_enable_or_refresh_n_o <= 1'b1;
      end else if (clk_en_i) begin
         output_enable_or_refresh_n_o <= // see R4 R5
            !((acc_nxt && !wr_nxt) || rf_nxt);
      end
   end

   // address and write data set up together with the enable fall
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         addr_bus_o <= '0;
         data_pins_o <= '0;
      end else if (clk_en_i) begin
         if (state_r == PSRI_S_IDLE && acc_nxt) begin
            addr_bus_o <= req_i.addr; // see R1 R2
            data_pins_o <= req_i.wdata;
         end else if (state_r == PSRI_S_ACC) begin
            data_pins_o <= cur_r.wdata;
         end
      end
   end

   // data pins driven only while the strobe is low
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         data_pins_oe_n_o <= 1'b1;
      end else if (clk_en_i) begin
         data_pins_oe_n_o <= !(acc_nxt && wr_nxt);
      end
   end

   // read data sampled in the last cycle of the read phase
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_o <= '0;
         rdata_valid_o <= 1'b0;
      end else if (clk_en_i) begin
         rdata_valid_o <= 1'b0;
         if (state_r == PSRI_S_ACC && tmr_r == c(1) && !wr_phase_r &&
             cur_r.op != PSRI_OP_WRITE) begin
            rdata_o <= data_pins_i;
            rdata_valid_o <= 1'b1;
         end
      end
   end
endmodule : psri_ctrl

// ### bench/psri_ctrl_props.sv
// Purpose: pin timing checks for the psram controller
// Assumes: 25 ns cycle, slowest-grade cycle counts
// Notes: pause and self refresh counts follow the parameters
`timescale 1ns/10ps
module psri_ctrl_props
   import psri_pkg::*;
#(
   parameter int unsigned PAUSE_CYC = 20,
   parameter int unsigned SELF_CYC = 10
) (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic ce_n_o,
   input wire logic output_enable_or_refresh_n_o,
   input wire logic rw_n_o,
   input wire logic data_pins_oe_n_o
);
   wire rf_n = output_enable_or_refresh_n_o;
   logic [15:0] pause_r;
   logic [15:0] low_r;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) pause_r <= 16'h0000;
      else if (pause_r < 16'(PAUSE_CYC)) pause_r <= pause_r + 16'h0001;
   end
   // length of a refresh pin low pulse taken with chip enable high
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) low_r <= 16'h0000;
      else low_r <= (!rf_n && ce_n_o) ? low_r + 16'h0001 : 16'h0000;
   end
   property p_pause; pause_r < 16'(PAUSE_CYC) |-> ce_n_o && rf_n; endproperty
   a_pause: assert property (p_pause)
      else $error("pins active in pause");
   property p_ce_low; $fell(ce_n_o) |-> (!ce_n_o)[*4]; endproperty
   a_ce_low: assert property (p_ce_low)
      else $error("enable pulse short");
   property p_ce_high; $rose(ce_n_o) |-> ce_n_o[*2]; endproperty
   a_ce_high: assert property (p_ce_high)
      else $error("precharge short");
   property p_cycle; $fell(ce_n_o) |=> (!$fell(ce_n_o))[*6]; endproperty
   a_cycle: assert property (p_cycle)
      else $error("cycles too close");
   property p_drive; !data_pins_oe_n_o |-> !ce_n_o && !rw_n_o && rf_n;
   endproperty
   a_drive: assert property (p_drive)
      else $error("bus driven outside write");
   property p_wp; $fell(rw_n_o) |-> (!rw_n_o && !ce_n_o)[*2]; endproperty
   a_wp: assert property (p_wp)
      else $error("strobe short");
   property p_rfd;
      $fell(rf_n) && ce_n_o |-> $past(ce_n_o) && $past(ce_n_o, 2);
   endproperty
   a_rfd: assert property (p_rfd)
      else $error("refresh too soon");
   property p_fap; $fell(rf_n) && ce_n_o |-> (!rf_n)[*2]; endproperty
   a_fap: assert property (p_fap)
      else $error("refresh pulse short");
   property p_frs;
      $rose(rf_n) && ce_n_o && low_r >= 16'(SELF_CYC) |-> ce_n_o[*8];
   endproperty
   a_frs: assert property (p_frs)
      else $error("enable early after self refresh");
endmodule : psri_ctrl_props
bind psri_ctrl psri_ctrl_props #(.PAUSE_CYC(PAUSE_CYC), .SELF_CYC(SELF_CYC))
   psri_ctrl_props_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
   .ce_n_o(ce_n_o), .rw_n_o(rw_n_o), .data_pins_oe_n_o(data_pins_oe_n_o),
   .output_enable_or_refresh_n_o(output_enable_or_refresh_n_o));

// ### bench/psri_psram_model.sv
// Purpose: behavioural pseudo-static ram facing the controller
// Assumes: ideal levels, no setup or hold checks
// Notes: refresh kind is told by the low pulse length
`timescale 1ns/10ps
module psri_psram_model
   import psri_pkg::*;
#(
   parameter realtime SELF_NS = 8000.0
) (
   input wire logic ce_n_i,
   input wire logic output_enable_or_refresh_n_i,
   input wire logic rw_n_i,
   input wire logic [PSRI_ADDR_W-1:0] addr_i,
   input wire logic [PSRI_DATA_W-1:0] data_i,
   output logic [PSRI_DATA_W-1:0] data_o,
   output logic data_en_o,
   output int auto_cnt_o,
   output int self_cnt_o,
   output logic [PSRI_ROW_W-1:0] row_o
);
   logic [7:0] mem [0:(1<<PSRI_ADDR_W)-1];
   logic [PSRI_ADDR_W-1:0] addr_r;
   logic armed = 1'b0;
   realtime t_low = 0.0;
   realtime t_ce = 0.0;
   initial begin
      auto_cnt_o = 0;
      self_cnt_o = 0;
      row_o = 11'h000;
   end
   always @(negedge ce_n_i) begin
      addr_r = addr_i;
      armed = !rw_n_i;
   end
   always @(negedge rw_n_i) if (!ce_n_i) armed = 1'b1;
   // the first rising edge stores; the second finds nothing armed
   always @(posedge rw_n_i or posedge ce_n_i) begin
      if (armed) mem[addr_r] = data_i;
      armed = 1'b0;
   end
   assign data_en_o = !ce_n_i && !output_enable_or_refresh_n_i && rw_n_i;
   assign data_o = mem[addr_r];
   always @(ce_n_i) t_ce = $realtime;
   always @(negedge output_enable_or_refresh_n_i) t_low = $realtime;
   always @(posedge output_enable_or_refresh_n_i) begin
      if (ce_n_i && t_ce < t_low) begin
         if ($realtime - t_low >= SELF_NS) self_cnt_o++;
         else begin
            auto_cnt_o++;
            row_o = row_o + 11'h001;
         end
      end
   end
endmodule : psri_psram_model

// ### bench/pseudo_static_ram_interface_tb_top.sv
// Purpose: self-checking bench for the psram controller
// Assumes: shortened pause, self refresh and refresh counts
// Notes: bus settles 1 ns after edges, giving the model hold time
`timescale 1ns/10ps
module pseudo_static_ram_interface_tb_top;
   import psri_pkg::*;
   localparam int unsigned SELF_C = 10;
   logic core_clk_i, resetn_i, clk_en_i, req_valid_i, sleep_i;
   logic req_ready_o, rdata_valid_o, in_self, ce_n, rf_n, rw_n;
   logic d_oe_n, dev_en;
   psri_req_type req_i;
   logic [PSRI_ADDR_W-1:0] addr_bus;
   logic [7:0] rdata, d_ctl, d_dev;
   logic [7:0] last_r = 8'h00;
   logic [PSRI_ROW_W-1:0] row;
   wire [7:0] bus;
   int auto_cnt, self_cnt, n_errors, n_compared;
   // a released bus shows the inverse of its last level, not a stale copy
   assign #1 bus = dev_en ? d_dev : !d_oe_n ? d_ctl : ~last_r;
   always @(posedge core_clk_i) if (dev_en || !d_oe_n) last_r <= bus;
   psri_ctrl #(.PAUSE_CYC(20), .SELF_CYC(SELF_C), .REF_INT_CYC(50))
      psri_ctrl_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
      .clk_en_i(clk_en_i), .req_i(req_i), .req_valid_i(req_valid_i),
      .req_ready_o(req_ready_o), .sleep_i(sleep_i),
      .rdata_valid_o(rdata_valid_o), .rdata_o(rdata),
      .in_self_refresh_o(in_self), .ce_n_o(ce_n),
      .output_enable_or_refresh_n_o(rf_n), .rw_n_o(rw_n),
      .addr_bus_o(addr_bus), .data_pins_o(d_ctl),
      .data_pins_oe_n_o(d_oe_n), .data_pins_i(bus));
   psri_psram_model #(.SELF_NS(SELF_C * 25.0)) psri_psram_model_inst (
      .ce_n_i(ce_n), .output_enable_or_refresh_n_i(rf_n), .rw_n_i(rw_n),
      .addr_i(addr_bus), .data_i(bus), .data_o(d_dev), .data_en_o(dev_en),
      .auto_cnt_o(auto_cnt), .self_cnt_o(self_cnt), .row_o(row));
   initial begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
      end
   endtask : chk
   task automatic results();
      $display("compared %0d, mismatched %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : results
   task automatic hang();
      n_errors++;
      $display("unexpected at %0t: wait ran out", $time);
      results();
   endtask : hang
   // request is held until an edge sees ready high
   task automatic xfer(input psri_op_type op, input logic [18:0] a,
                       input logic [7:0] d, output logic [7:0] v);
      int i;
      @(posedge core_clk_i);
      req_i <= '{op: op, addr: a, wdata: d};
      req_valid_i <= 1'b1;
      @(negedge core_clk_i);
      for (i = 0; i < 500 && req_ready_o !== 1'b1; i++) @(negedge core_clk_i);
      if (i == 500) hang();
      @(posedge core_clk_i);
      req_valid_i <= 1'b0;
      v = 8'h00;
      if (op == PSRI_OP_WRITE) return;
      for (i = 0; i < 20 && rdata_valid_o !== 1'b1; i++) @(negedge core_clk_i);
      if (i == 20) hang();
      v = rdata;
   endtask : xfer
   task automatic t_rw();
      logic [7:0] v;
      xfer(PSRI_OP_WRITE, 19'h00000, 8'haa, v);
      xfer(PSRI_OP_WRITE, 19'h7ffff, 8'h55, v);
      xfer(PSRI_OP_RMW, 19'h12345, 8'h3c, v);
      xfer(PSRI_OP_READ, 19'h7ffff, 8'h00, v);
      chk(v, 8'h55);
      xfer(PSRI_OP_RMW, 19'h12345, 8'hc3, v);
      chk(v, 8'h3c);
      xfer(PSRI_OP_READ, 19'h12345, 8'h00, v);
      chk(v, 8'hc3);
      $display("test read write done");
   endtask : t_rw
   task automatic t_freeze();
      logic [3:0] s;
      int bad;
      bad = 0;
      @(posedge core_clk_i);
      clk_en_i <= 1'b0;
      @(negedge core_clk_i);
      s = {ce_n, rf_n, rw_n, req_ready_o};
      repeat (10) begin
         @(negedge core_clk_i);
         if ({ce_n, rf_n, rw_n, req_ready_o} !== s) bad++;
      end
      chk(bad, 0);
      @(posedge core_clk_i);
      clk_en_i <= 1'b1;
      $display("test freeze done");
   endtask : t_freeze
   task automatic t_refresh();
      int a;
      a = auto_cnt;
      repeat (130) @(negedge core_clk_i);
      chk(auto_cnt - a >= 2, 1);
      chk(row, auto_cnt[10:0]);
      $display("test refresh done");
   endtask : t_refresh
   task automatic t_sleep();
      int s, i;
      logic [7:0] v;
      s = self_cnt;
      @(posedge core_clk_i);
      sleep_i <= 1'b1;
      for (i = 0; i < 300 && in_self !== 1'b1; i++) @(negedge core_clk_i);
      if (i == 300) hang();
      repeat (20) @(negedge core_clk_i);
      @(posedge core_clk_i);
      sleep_i <= 1'b0;
      xfer(PSRI_OP_READ, 19'h00000, 8'h00, v);
      chk(v, 8'haa);
      chk(self_cnt - s, 1);
      $display("test self refresh done");
   endtask : t_sleep
   initial begin
      n_errors = 0;
      n_compared = 0;
      resetn_i = 1'b0;
      clk_en_i = 1'b1;
      req_valid_i = 1'b0;
      sleep_i = 1'b0;
      req_i = '0;
      repeat (3) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      @(negedge core_clk_i);
      chk({ce_n, rf_n, rw_n, d_oe_n, req_ready_o}, 5'h1e);
      t_rw();
      t_freeze();
      t_refresh();
      t_sleep();
      results();
   end
endmodule : pseudo_static_ram_interface_tb_top
